// ===== rtl/lcd_timing_pkg.sv
package lcd_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rates and derived cycle counts
    localparam int CLOCK_HZ = 25_000_000;
    localparam int LCD_FAST_HZ = 2048;
    localparam int LCD_SLOW_HZ = 128;
    localparam int BLINK_STEP_MS = 250;
    localparam int MS_PER_S = 1000;
    localparam int FAST_CYCLES = CLOCK_HZ / LCD_FAST_HZ;
    localparam int SLOW_CYCLES = CLOCK_HZ / LCD_SLOW_HZ;
    localparam int BLINK_STEP_CYCLES = (CLOCK_HZ / MS_PER_S) * BLINK_STEP_MS;
    localparam int BASE_COUNT_W = 18;
    localparam int STEP_COUNT_W = 23;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_MAIN = 10'h095;
    localparam logic [9:0] IDX_CLOCK = 10'h096;
    localparam logic [9:0] IDX_LADDER = 10'h09C;
    localparam logic [9:0] IDX_UPDATE = 10'h0B1;
    localparam logic [9:0] IDX_STATUS = 10'h0F0;
    localparam logic [ADDR_W-1:0] ADDR_MAIN = {IDX_MAIN, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CLOCK = {IDX_CLOCK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LADDER = {IDX_LADDER, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_UPDATE = {IDX_UPDATE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Field positions, masks and reset values
    localparam int MAIN_EN_BIT = 7;
    localparam int MAIN_BLINK_BIT = 5;
    localparam int MAIN_LCD_CLK_SELECT_BIT = 3;
    localparam int MAIN_MUX_LSB = 0;
    localparam int LADDER_BIT = 6;
    localparam int INVERT_BIT = 6;
    localparam int DONE_BIT = 1;
    localparam int HOLD_BIT = 0;
    localparam int SOURCE_LSB = 6;
    localparam int RATE_LSB = 4;
    localparam int DIVIDER_LSB = 0;
    localparam logic [7:0] LADDER_MASK = 8'h40;
    localparam logic [7:0] UPDATE_WMASK = 8'h41;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int SEG_COUNT = 108;

    ////////////////////////////////////////////////////////////////////////////
    // Drive divide ratios, in lcd_base_clk periods
    localparam logic [7:0] DIV_ONE = 8'h01;
    localparam logic [7:0] DIV_TWO = 8'h02;
    localparam logic [7:0] DIV_FOUR = 8'h04;
    localparam logic [7:0] DIV_SIX = 8'h06;
    localparam logic [7:0] DIV_EIGHT = 8'h08;
    localparam logic [7:0] DIV_FAST_CODE0 = 8'h40;
    localparam logic [7:0] DIV_FAST_2X_CODE0 = 8'h80;

    // Blink half periods in 250 ms steps
    localparam logic [3:0] HALF_2HZ = 4'h1;
    localparam logic [3:0] HALF_1HZ = 4'h2;
    localparam logic [3:0] HALF_HALF_HZ = 4'h4;
    localparam logic [3:0] HALF_THIRD_HZ = 4'h6;
    localparam logic [3:0] HALF_QUARTER_HZ = 4'h8;

    typedef enum logic [1:0] {
        MUX_RESERVED = 2'h0,
        MUX_TWO = 2'h1,
        MUX_THREE = 2'h2,
        MUX_FOUR = 2'h3
    } mux_level_type;

    typedef enum logic [1:0] {
        BLINK_OFF = 2'h0,
        BLINK_ON = 2'h1,
        BLINK_FIXED = 2'h2,
        BLINK_RATE = 2'h3
    } blink_source_type;

    typedef enum logic [2:0] {
        UPD_SHOWING = 3'h1,
        UPD_HELD = 3'h2,
        UPD_PENDING = 3'h4
    } update_state_type;

endpackage : lcd_timing_pkg

// ===== rtl/frame_timing_if.sv
`timescale 1ns/1ps
interface frame_timing_if;
    logic lcd_clk_select;
    logic [1:0] mux_level;
    logic [3:0] frame_divider;
    logic drive_tick;
    logic frame_start;
    logic [1:0] com_phase;

    modport timer (
        input lcd_clk_select,
        input mux_level,
        input frame_divider,
        output drive_tick,
        output frame_start,
        output com_phase
    );

    modport user (
        output lcd_clk_select,
        output mux_level,
        output frame_divider,
        input drive_tick,
        input frame_start,
        input com_phase
    );
endinterface : frame_timing_if

// ===== rtl/lcd_frame_timer.sv
`timescale 1ns/1ps
module lcd_frame_timer
    import lcd_timing_pkg::*;
#(
    parameter int FAST_PERIOD = FAST_CYCLES,
    parameter int SLOW_PERIOD = SLOW_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    frame_timing_if.timer tif
);

    logic [BASE_COUNT_W-1:0] base_count;
    logic [7:0] drive_count;
    logic [1:0] com_count;
    logic drive_tick;
    logic frame_start;
    logic [1:0] com_phase;

    ////////////////////////////////////////////////////////////////////////////
    // Drive divide ratio per clock select, multiplex level and divider code
    function automatic logic [7:0] drive_divide(input logic slow, input logic [1:0] mux,
                                                 input logic [3:0] code);
        logic [7:0] twice;
        twice = 8'({code, 1'b0}) + DIV_TWO;
        if (slow) begin
            if (code == 4'h0) begin
                drive_divide = DIV_TWO;
            end else if (code == 4'hF) begin
                drive_divide = DIV_ONE;
            end else if (mux == MUX_THREE || mux == MUX_FOUR) begin
                drive_divide = DIV_FOUR;
            end else if (code == 4'h1) begin
                drive_divide = DIV_FOUR;
            end else if (code == 4'h2) begin
                drive_divide = DIV_SIX;
            end else begin
                drive_divide = DIV_EIGHT;
            end
        end else if (mux == MUX_THREE || mux == MUX_FOUR) begin
            if (code == 4'h0) begin
                drive_divide = DIV_FAST_CODE0;
            end else if (code == 4'h1) begin
                drive_divide = (mux == MUX_FOUR) ? DIV_FOUR : DIV_SIX;
            end else if (code == 4'h2) begin
                drive_divide = DIV_SIX;
            end else begin
                drive_divide = twice;
            end
        end else begin
            drive_divide = (code == 4'h0) ? DIV_FAST_2X_CODE0 : 8'({twice, 1'b0});
        end
    endfunction : drive_divide

    wire [BASE_COUNT_W-1:0] base_last = tif.lcd_clk_select ?
        BASE_COUNT_W'(SLOW_PERIOD - 1) : BASE_COUNT_W'(FAST_PERIOD - 1);
    wire base_tick = (base_count >= base_last);
    wire [7:0] drive_last = drive_divide(tif.lcd_clk_select, tif.mux_level,
                                         tif.frame_divider) - DIV_ONE;
    wire drive_wrap = base_tick && (drive_count >= drive_last);
    // Reserved multiplex code runs as two-way so the frame never stalls
    wire [1:0] com_last = (tif.mux_level == MUX_FOUR) ? 2'h3 :
                          (tif.mux_level == MUX_THREE) ? 2'h2 : 2'h1;
    wire com_wrap = drive_wrap && (com_count >= com_last);
    // Phase leaves with the count, so index 0 marks the frame start
    wire [1:0] next_com = com_wrap ? 2'h0 : (drive_wrap ? com_count + 2'h1 : com_count);

    always_ff @(posedge clock) begin
        if (reset) begin
            base_count <= '0;
            drive_count <= '0;
            com_count <= '0;
            drive_tick <= 1'b0;
            frame_start <= 1'b0;
            com_phase <= 2'h0;
        end else begin
            base_count <= base_tick ? '0 : base_count + 1'b1;
            drive_count <= drive_wrap ? '0 : (base_tick ? drive_count + 1'b1 : drive_count);
            com_count <= next_com;
            drive_tick <= drive_wrap;
            frame_start <= com_wrap;
            com_phase <= next_com;
        end
    end

    assign tif.drive_tick = drive_tick;
    assign tif.frame_start = frame_start;
    assign tif.com_phase = com_phase;

endmodule : lcd_frame_timer

// ===== rtl/lcd_frame_blink_refresh_ctrl.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module lcd_frame_blink_refresh_ctrl
    import lcd_timing_pkg::*;
#(
    parameter int FAST_PERIOD = FAST_CYCLES,
    parameter int SLOW_PERIOD = SLOW_CYCLES,
    parameter int BLINK_STEP = BLINK_STEP_CYCLES
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Segment data memory contents
    input wire logic [SEG_COUNT-1:0] SEG_MEMORY,
    // Panel side
    output logic [SEG_COUNT-1:0] SEG_IMAGE,
    output logic DISPLAY_ON,
    output logic FRAME_INVERT,
    output logic EXT_LADDER_EN,
    output logic LCD_ENABLE,
    output logic [1:0] MUX_LEVEL,
    output logic DRIVE_TICK,
    output logic FRAME_START,
    output logic [1:0] COM_PHASE
);

    ////////////////////////////////////////////////////////////////////////////
    // Written configuration and the copies applied to the panel
    logic [7:0] main_cfg;
    logic [7:0] lcd_clock_blink_cfg;
    logic [7:0] lcd_ladder_cfg;
    logic [7:0] update_ctrl;

    logic [7:0] applied_main;
    logic [7:0] applied_clock;
    logic [7:0] applied_ladder;
    logic applied_invert;

    // Refresh handshake and frame polarity
    logic update_done_flag;
    update_state_type update_state;
    update_state_type next_update_state;
    logic invert_phase;

    // Blink generator
    logic blink_phase;
    logic [STEP_COUNT_W-1:0] step_count;
    logic [3:0] half_count;

    // Bus answer
    logic ready;
    logic [31:0] rdata;
    logic slverr;

    // Output flip-flops
    logic [SEG_COUNT-1:0] seg_image;
    logic display_on;
    logic ext_ladder_en;
    logic lcd_enable;
    logic [1:0] mux_out;
    logic drive_pulse;
    logic frame_pulse;
    logic [1:0] com_out;

    // Frame, drive and common timing
    frame_timing_if tif ();

    lcd_frame_timer #(
        .FAST_PERIOD(FAST_PERIOD),
        .SLOW_PERIOD(SLOW_PERIOD)
    ) timer (
        .clock(CLOCK),
        .reset(SRST),
        .tif(tif)
    );

    // Timer sees only applied settings, so a frame never mixes two timings
    assign tif.lcd_clk_select = applied_main[MAIN_LCD_CLK_SELECT_BIT];
    assign tif.mux_level = applied_main[MAIN_MUX_LSB +: 2];
    assign tif.frame_divider = applied_clock[DIVIDER_LSB +: 4];

    // Internal frame start; FRAME_START follows a cycle later
    wire frame_edge = tif.frame_start;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup_or_access = PSEL && PENABLE;
    wire access_done = setup_or_access && ready;
    wire write_done = access_done && PWRITE;
    wire hit_main = (PADDR == ADDR_MAIN);
    wire hit_clock = (PADDR == ADDR_CLOCK);
    wire hit_ladder = (PADDR == ADDR_LADDER);
    wire hit_update = (PADDR == ADDR_UPDATE);
    wire hit_status = (PADDR == ADDR_STATUS);
    wire hit_any = hit_main || hit_clock || hit_ladder || hit_update || hit_status;

    // Strobes fire only at the completing edge
    wire write_main = write_done && hit_main;
    wire write_clock = write_done && hit_clock;
    wire write_ladder = write_done && hit_ladder;
    wire write_update = write_done && hit_update;
    // Done flag clears on a written one; holding the bit at zero leaves it alone
    wire done_clear = write_update && PWDATA[DONE_BIT];
    wire hold = update_ctrl[HOLD_BIT];

    // Read data selection
    wire [7:0] update_view = {update_ctrl[7:2], update_done_flag, update_ctrl[HOLD_BIT]};
    // Bit 6 shows whether inversion is on for the frame being driven
    wire [7:0] status_view = {1'b0, applied_invert, com_out,
                              update_state == UPD_PENDING,
                              update_state == UPD_HELD,
                              invert_phase, display_on};
    wire [7:0] read_byte = hit_main ? main_cfg :
                           hit_clock ? lcd_clock_blink_cfg :
                           hit_ladder ? lcd_ladder_cfg :
                           hit_update ? update_view :
                           hit_status ? status_view : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer registered
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ready <= 1'b0;
            rdata <= 32'h0000_0000;
            slverr <= 1'b0;
        end else begin
            ready <= setup_or_access && !ready;
            rdata <= (setup_or_access && !ready && !PWRITE) ? {24'h00_0000, read_byte} : rdata;
            // Error stands only in the ready cycle
            slverr <= setup_or_access && !ready && !hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            main_cfg <= CFG_RESET;
            lcd_clock_blink_cfg <= CFG_RESET;
            lcd_ladder_cfg <= CFG_RESET;
            update_ctrl <= CFG_RESET;
        end else begin
            // Main and clock registers keep every written bit
            if (write_main) begin
                main_cfg <= PWDATA[7:0];
            end
            if (write_clock) begin
                lcd_clock_blink_cfg <= PWDATA[7:0];
            end
            // Reserved ladder bits are not stored and read back zero
            if (write_ladder) begin
                lcd_ladder_cfg <= PWDATA[7:0] & LADDER_MASK;
            end
            // Only invert and hold are stored; reserved bits stay clear
            if (write_update) begin
                update_ctrl <= PWDATA[7:0] & UPDATE_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings take effect at the frame boundary
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            applied_main <= CFG_RESET;
            applied_clock <= CFG_RESET;
            applied_ladder <= CFG_RESET;
            applied_invert <= 1'b0;
        end else if (frame_edge) begin
            applied_main <= main_cfg;
            applied_clock <= lcd_clock_blink_cfg;
            applied_ladder <= lcd_ladder_cfg;
            applied_invert <= update_ctrl[INVERT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame inversion
    // Next frame flips only while inversion is on for it
    wire next_invert = update_ctrl[INVERT_BIT] && !invert_phase;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            invert_phase <= 1'b0;
        end else if (frame_edge) begin
            invert_phase <= next_invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refresh handshake; hold acts at once, loading waits for a frame start
    always_comb begin
        next_update_state = update_state;
        case (update_state)
            UPD_SHOWING: begin
                if (hold) begin
                    next_update_state = UPD_HELD;
                end
            end
            UPD_HELD: begin
                if (!hold) begin
                    next_update_state = UPD_PENDING;
                end
            end
            UPD_PENDING: begin
                if (hold) begin
                    next_update_state = UPD_HELD;
                end else if (frame_edge) begin
                    next_update_state = UPD_SHOWING;
                end
            end
            default: begin
                next_update_state = UPD_SHOWING;
            end
        endcase
    end

    // Held image stays put until a frame start after release
    wire load_image = frame_edge && !hold &&
                      (update_state == UPD_SHOWING || update_state == UPD_PENDING);
    wire done_set = frame_edge && !hold && (update_state == UPD_PENDING);

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            update_state <= UPD_SHOWING;
            update_done_flag <= 1'b0;
            seg_image <= '0;
        end else begin
            update_state <= next_update_state;
            // A pending load finishing in the clearing cycle still leaves the flag set
            update_done_flag <= done_set || (update_done_flag && !done_clear);
            if (load_image) begin
                seg_image <= SEG_MEMORY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Blink generator, stepped in quarter seconds so it is independent of
    // the LCD clock select
    wire [1:0] source = applied_clock[SOURCE_LSB +: 2];
    wire [1:0] rate = applied_clock[RATE_LSB +: 2];
    wire [3:0] half_last = (source == BLINK_FIXED) ? HALF_2HZ :
                           (rate == 2'h0) ? HALF_1HZ :
                           (rate == 2'h1) ? HALF_HALF_HZ :
                           (rate == 2'h2) ? HALF_THIRD_HZ : HALF_QUARTER_HZ;
    wire step_tick = (step_count >= STEP_COUNT_W'(BLINK_STEP - 1));
    wire half_wrap = step_tick && (half_count >= half_last - 4'h1);

    // Counter runs only for the timed sources
    wire blink_running = applied_main[MAIN_BLINK_BIT] && source[1];
    wire blink_view = !applied_main[MAIN_BLINK_BIT] ? 1'b1 :
                      (source == BLINK_OFF) ? 1'b0 :
                      (source == BLINK_ON) ? 1'b1 : blink_phase;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            step_count <= '0;
            half_count <= 4'h0;
            blink_phase <= 1'b1;
        end else if (!blink_running) begin
            // Restart cleanly so the first blink half is full length
            step_count <= '0;
            half_count <= 4'h0;
            blink_phase <= 1'b1;
        end else begin
            step_count <= step_tick ? '0 : step_count + 1'b1;
            half_count <= half_wrap ? 4'h0 : (step_tick ? half_count + 4'h1 : half_count);
            if (half_wrap) begin
                blink_phase <= !blink_phase;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered panel outputs
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            display_on <= 1'b0;
            ext_ladder_en <= 1'b0;
            lcd_enable <= 1'b0;
            mux_out <= 2'h0;
            drive_pulse <= 1'b0;
            frame_pulse <= 1'b0;
            com_out <= 2'h0;
        end else begin
            display_on <= blink_view;
            ext_ladder_en <= applied_ladder[LADDER_BIT];
            lcd_enable <= applied_main[MAIN_EN_BIT];
            mux_out <= applied_main[MAIN_MUX_LSB +: 2];
            // Timer strobes, one cycle behind the timer
            drive_pulse <= tif.drive_tick;
            frame_pulse <= tif.frame_start;
            com_out <= tif.com_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ports straight from the flip-flops
    assign PRDATA = rdata;
    assign PREADY = ready;
    assign PSLVERR = slverr;
    assign SEG_IMAGE = seg_image;
    assign DISPLAY_ON = display_on;
    assign FRAME_INVERT = invert_phase;
    assign EXT_LADDER_EN = ext_ladder_en;
    assign LCD_ENABLE = lcd_enable;
    assign MUX_LEVEL = mux_out;
    assign DRIVE_TICK = drive_pulse;
    assign FRAME_START = frame_pulse;
    assign COM_PHASE = com_out;

endmodule : lcd_frame_blink_refresh_ctrl

// ===== test/lcd_ctrl_assertions.sv
`timescale 1ns/1ps
module lcd_ctrl_assertions
    import lcd_timing_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SRST,
    // Bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] PRDATA,
    // Panel
    input wire logic [SEG_COUNT-1:0] SEG_IMAGE,
    input wire logic FRAME_START,
    input wire logic DRIVE_TICK,
    input wire logic FRAME_INVERT,
    input wire logic EXT_LADDER_EN,
    input wire logic [1:0] MUX_LEVEL
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence
    ////////////////////////////////////////
    a_ready_timing: assert property (s_setup ##1 s_access |=> PREADY)
        else $error("ready missing in second access cycle");
    a_ready_once: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (PREADY |-> s_access)
        else $error("ready outside access phase");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_rdata_upper: assert property (PRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_image_frame: assert property (!$stable(SEG_IMAGE) |-> FRAME_START)
        else $error("image changed inside a frame");
    a_invert_frame: assert property ($changed(FRAME_INVERT) |-> FRAME_START)
        else $error("polarity changed inside a frame");
    a_ladder_frame: assert property ($changed(EXT_LADDER_EN) |-> $past(FRAME_START))
        else $error("ladder changed inside a frame");
    a_mux_frame: assert property ($changed(MUX_LEVEL) |-> $past(FRAME_START))
        else $error("mux level changed inside a frame");
    a_frame_pulse: assert property (FRAME_START |=> !FRAME_START [*8])
        else $error("frame pulses too close");
    a_drive_pulse: assert property (DRIVE_TICK |=> !DRIVE_TICK)
        else $error("drive tick longer than one cycle");
endmodule : lcd_ctrl_assertions

bind lcd_frame_blink_refresh_ctrl lcd_ctrl_assertions chk_u (
    .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .SEG_IMAGE(SEG_IMAGE), .FRAME_START(FRAME_START), .DRIVE_TICK(DRIVE_TICK),
    .FRAME_INVERT(FRAME_INVERT), .EXT_LADDER_EN(EXT_LADDER_EN), .MUX_LEVEL(MUX_LEVEL)
);

// ===== test/lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model
    import lcd_timing_pkg::*;
(
    // Clock
    input wire logic clock,
    // Drive side
    input wire logic frame_start,
    input wire logic [SEG_COUNT-1:0] seg_image,
    // What the glass shows
    output logic [SEG_COUNT-1:0] shown
);
    // Glass only settles on a new pattern once a frame begins
    always_ff @(posedge clock) begin
        if (frame_start) begin
            shown <= seg_image;
        end
    end
endmodule : lcd_panel_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import lcd_timing_pkg::*;
;
    logic CLOCK = 0;
    logic SRST = 1;
    logic PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [ADDR_W-1:0] PADDR = '0;
    logic [31:0] PWDATA = '0;
    logic [SEG_COUNT-1:0] SEG_MEMORY = '0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, DISPLAY_ON, FRAME_INVERT, EXT_LADDER_EN, LCD_ENABLE;
    wire DRIVE_TICK, FRAME_START;
    wire [1:0] MUX_LEVEL, COM_PHASE;
    wire [SEG_COUNT-1:0] SEG_IMAGE, shown;
    int err_total = 0, comparisons = 0, cycles = 0, n;
    logic v;
    logic [7:0] mc [6] = '{8'h81, 8'h81, 8'h82, 8'h82, 8'h83, 8'h8B};
    logic [7:0] cc [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h02, 8'h0F};
    int len [6] = '{64, 1024, 72, 768, 96, 32};

    lcd_frame_blink_refresh_ctrl #(.FAST_PERIOD(4), .SLOW_PERIOD(8), .BLINK_STEP(20)) dut_u (
        .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SEG_MEMORY(SEG_MEMORY), .SEG_IMAGE(SEG_IMAGE),
        .DISPLAY_ON(DISPLAY_ON), .FRAME_INVERT(FRAME_INVERT),
        .EXT_LADDER_EN(EXT_LADDER_EN), .LCD_ENABLE(LCD_ENABLE), .MUX_LEVEL(MUX_LEVEL),
        .DRIVE_TICK(DRIVE_TICK), .FRAME_START(FRAME_START), .COM_PHASE(COM_PHASE));
    lcd_panel_model panel_u (.clock(CLOCK), .frame_start(FRAME_START),
        .seg_image(SEG_IMAGE), .shown(shown));

    always #20 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q, output logic e);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        // Slave latency is not assumed; the cycle ceiling ends a hang
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 8'h00, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd
    task automatic frames(input int k);
        repeat (k) begin
            do @(negedge CLOCK); while (FRAME_START !== 1'b1);
        end
    endtask : frames
    // First pass aligns to an event, second pass measures the spacing
    task automatic gap(input bit b, output int c);
        logic p;
        for (int i = 0; i < 2; i++) begin
            c = 0;
            p = DISPLAY_ON;
            do begin
                @(negedge CLOCK);
                c++;
            end while (b ? DISPLAY_ON === p : FRAME_START !== 1'b1);
        end
    endtask : gap
    task automatic results;
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    task automatic t_regs;
        rd(ADDR_CLOCK, 32'h0, 1'b0);
        rd(ADDR_LADDER, 32'h0, 1'b0);
        rd(ADDR_UPDATE, 32'h0, 1'b0);
        rd(12'h004, 32'h0, 1'b1);
        wr(ADDR_LADDER, 8'h40);
        frames(2);
        chk(EXT_LADDER_EN, 1'b1);
        chk(LCD_ENABLE, 1'b0);
        rd(ADDR_LADDER, 32'h40, 1'b0);
        wr(ADDR_LADDER, 8'h00);
        frames(2);
        chk(EXT_LADDER_EN, 1'b0);
    endtask : t_regs
    task automatic t_rates;
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_MAIN, mc[i]);
            wr(ADDR_CLOCK, cc[i]);
            frames(2);
            gap(1'b0, n);
            chk(n, len[i]);
            chk(MUX_LEVEL, mc[i][1:0]);
            chk(COM_PHASE, 2'h0);
            chk(LCD_ENABLE, mc[i][7]);
            rd(ADDR_MAIN, {24'h0, mc[i]}, 1'b0);
        end
    endtask : t_rates
    task automatic t_invert;
        wr(ADDR_UPDATE, 8'h40);
        frames(2);
        v = FRAME_INVERT;
        frames(1);
        chk(FRAME_INVERT, !v);
        frames(1);
        chk(FRAME_INVERT, v);
        wr(ADDR_UPDATE, 8'h00);
        frames(3);
        chk(FRAME_INVERT, 1'b0);
    endtask : t_invert
    task automatic t_hold;
        @(posedge CLOCK);
        SEG_MEMORY <= {27{4'hA}};
        frames(2);
        chk(shown[107:76], 32'hAAAAAAAA);
        wr(ADDR_UPDATE, 8'h01);
        @(posedge CLOCK);
        SEG_MEMORY <= {27{4'h5}};
        frames(2);
        chk(SEG_IMAGE[31:0], 32'hAAAAAAAA);
        rd(ADDR_UPDATE, 32'h1, 1'b0);
        wr(ADDR_UPDATE, 8'h00);
        frames(2);
        chk(SEG_IMAGE[31:0], 32'h55555555);
        rd(ADDR_UPDATE, 32'h2, 1'b0);
        wr(ADDR_UPDATE, 8'h02);
        rd(ADDR_UPDATE, 32'h0, 1'b0);
    endtask : t_hold
    task automatic t_blink;
        wr(ADDR_MAIN, 8'hA1);
        wr(ADDR_CLOCK, 8'h41);
        frames(2);
        chk(DISPLAY_ON, 1'b1);
        wr(ADDR_CLOCK, 8'h81);
        frames(2);
        gap(1'b1, n);
        chk(n, 20);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_CLOCK, {2'h3, r[1:0], 4'h1});
            frames(2);
            gap(1'b1, n);
            chk(n, 40 * (r + 1));
        end
        wr(ADDR_CLOCK, 8'h01);
        frames(2);
        chk(DISPLAY_ON, 1'b0);
        wr(ADDR_MAIN, 8'h81);
        frames(2);
        chk(DISPLAY_ON, 1'b1);
    endtask : t_blink

    initial begin
        repeat (20) @(posedge CLOCK);
        SRST <= 1'b0;
        t_regs();
        t_rates();
        wr(ADDR_MAIN, 8'h81);
        wr(ADDR_CLOCK, 8'h01);
        t_invert();
        t_hold();
        t_blink();
        results();
    end
endmodule : tb_top
